// ==== pkg/acd_pkg.sv ====
// acd_pkg.sv: types of the amplifier control and diagnostic serial port
// assumes: acd_regs.svh sits on the include path
`include "acd_regs.svh"
package acd_pkg;
   // control byte a
   typedef struct packed {
      logic mute_thr_high;
      logic diag_en;
      logic offset_det_en;
      logic front_gain_16db;
      logic rear_gain_16db;
      logic front_unmute;
      logic rear_unmute;
      logic clip_thr_10pct;
   } acd_ctrl_a_t;
   // control byte b
   typedef struct packed {
      logic cur_thr_low;
      logic spare;
      logic fast_mute;
      logic run;
      logic line_drv_diag;
      logic cur_diag_en;
      logic right_high_eff;
      logic left_high_eff;
   } acd_ctrl_b_t;
   // diagnostic byte a
   typedef struct packed {
      logic thermal_warn1;
      logic diag_done;
      logic ch1_open_cur;
      logic ch1_permanent;
      logic ch1_short_load;
      logic ch1_open_offset;
      logic ch1_short_supply;
      logic ch1_short_ground;
   } acd_diag_a_t;
   // all four diagnostic bytes, a in the top bits
   typedef struct packed {
      acd_diag_a_t a;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
   } acd_diag_t;
   // link states
   typedef enum logic [2:0] {
      ACD_IDLE = 3'b000,
      ACD_ADDR = 3'b001,
      ACD_AACK = 3'b011,
      ACD_WDAT = 3'b010,
      ACD_WACK = 3'b110,
      ACD_RDAT = 3'b111,
      ACD_RACK = 3'b101
   } acd_state_t;
endpackage

// ==== pkg/acd_regs.svh ====
// acd_regs.svh: constants of the amplifier control and diagnostic serial port
// assumes: included by the package and the design files, definitions only
// Functional notes
// - sda changes only while scl low
// - sda fall/rise during scl high: start/stop
// - eight data bits per byte, msb first
// - receiver pulls sda low during acknowledge
// - address bit zero picks write or read
// - write carries control_byte_a then control_byte_b
// - read returns diag_byte_a through diag_byte_d
// - control a bit7: mute threshold 8 V/6 V
// - control a bit6 enables load diagnostics
// - control a bit5 enables offset detection
// - control a bits4/3: front/rear gain 16 dB
// - control a bits2/1: unmute front/rear pair
// - control a bit0: clip threshold 10 percent
// - control b bit7: low current threshold
// - control b bit5: fast muting
// - control b bit4: leave standby, operate
// - control b bit3 line mode, bit2 current diag
// - control b bits1/0: right/left high efficiency
// - diag a bit7: first thermal warning
// - diag a bit6: diagnostic cycle terminated
// - diag a bit5: channel one open load
// - diag a bits4..2: mode, short, open/offset
// - diag a bits1/0: short supply/ground
// - address select pin sets address or disables
// - each read restarts diagnostic cycles
`ifndef ACD_REGS_SVH
`define ACD_REGS_SVH
// ******************************
// bus addresses
// ******************************
`define ACD_ADDR_LOW 7'h6c
`define ACD_ADDR_MID 7'h6d
`define ACD_ADDR_HIGH 7'h6e
`define ACD_SEL_LOW 2'h0
`define ACD_SEL_MID 2'h1
`define ACD_SEL_HIGH 2'h2
`define ACD_SEL_OPEN 2'h3
// ******************************
// byte counts and field positions
// ******************************
`define ACD_BYTE_BITS 4'h8
`define ACD_CTRL_BYTES 3'h2
`define ACD_DIAG_BYTES 3'h4
`define ACD_CTRL_RESET 8'h00
`define ACD_DIAG_RESET 8'h00
`define ACD_RW_BIT 0
`define ACD_STRAP_WAIT 2'h2
`endif

// ==== src/acd_port.sv ====
// acd_port.sv: two-wire slave port with control outputs and diagnostic inputs
// assumes: scl is the link clock; start/stop seen on sda edges; open-drain sda
`timescale 1ns/1ps
`default_nettype none
`include "acd_regs.svh"
module acd_port (
   input wire logic sys_clk_in, // 200 MHz system clock
   input wire logic nrst_in, // async reset, active low
   input wire logic scl_in, // serial clock from master
   input wire logic sda_in, // serial data line level
   output logic sda_out, // sda drive value, always low
   output logic sda_oe_out, // sda pull-down enable
   input wire logic [1:0] addr_sel_in, // address select pin class
   input wire acd_pkg::acd_diag_t diag_in, // live diagnostic results
   input wire logic diag_cycle_done_in, // diagnostic cycle finished
   output acd_pkg::acd_ctrl_a_t ctrl_a_out, // control byte a
   output acd_pkg::acd_ctrl_b_t ctrl_b_out, // control byte b
   output logic bus_enabled_out, // serial bus enabled
   output logic diag_restart_out // one-cycle pulse: restart diagnostics
);
   import acd_pkg::*;

   // ******************************
   // system side: strap capture and diagnostic latch
   // ******************************
   logic [1:0] addr_sel;
   logic sel_taken;
   logic [1:0] addr_sel_s;
   logic [1:0] settle;
   logic [6:0] own_addr;
   acd_diag_t diag_snap;
   acd_diag_t next_diag_snap;
   logic done_s;

   // strap pins pass two flops each before anything reads them
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_sel_sync
         acd_sync u_sel_sync (
            .clk_in(sys_clk_in),
            .nrst_in(nrst_in),
            .d_in(addr_sel_in[g]),
            .q_out(addr_sel_s[g])
         );
      end
   endgenerate

   // strap caught once, after the synchroniser has filled;
   // the address stays fixed until the next reset, so the link
   // domain may read it without a handshake
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         settle <= 2'h0;
         addr_sel <= `ACD_SEL_OPEN;
         sel_taken <= 1'b0;
      end else if (settle != `ACD_STRAP_WAIT) begin
         settle <= settle + 2'h1;
      end else if (!sel_taken) begin
         addr_sel <= addr_sel_s;
         sel_taken <= 1'b1;
      end
   end

   // address decode from strap; the open class never reaches the link,
   // whose reset it holds, so its address is a don't-care
   always_comb begin
      case (addr_sel)
         `ACD_SEL_LOW: own_addr = `ACD_ADDR_LOW;
         `ACD_SEL_MID: own_addr = `ACD_ADDR_MID;
         `ACD_SEL_HIGH: own_addr = `ACD_ADDR_HIGH;
         default: own_addr = `ACD_ADDR_LOW;
      endcase
   end

   // bus enabled once the strap is caught, unless pin is open
   // registered so the link reset below comes from a flop, not a decode
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bus_enabled_out <= 1'b0;
      end else begin
         bus_enabled_out <= sel_taken && (addr_sel != `ACD_SEL_OPEN);
      end
   end

   // cycle-done level comes from the diagnostic sequencer, not this clock
   acd_sync u_done_sync (
      .clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .d_in(diag_cycle_done_in),
      .q_out(done_s)
   );

   // snapshot handed to the link; bit6 shows cycle completion
   // the live bit replaces whatever the sequencer put there, so a
   // read reports completion as seen at the restart of the previous read
   always_comb begin
      next_diag_snap = diag_in;
      next_diag_snap.a.diag_done = done_s;
   end

   // ******************************
   // link side: serial clock domain
   // ******************************
   // byte engine
   acd_state_t state;
   logic [7:0] shreg;
   logic [2:0] bitcnt;
   logic [2:0] bytecnt;
   logic is_read;
   // start and stop detection
   logic start_seen;
   logic stop_seen;
   logic start_tgl;
   logic start_ack;
   // bytes handed to the system domain
   logic [7:0] ctrl_a_l;
   logic [7:0] ctrl_b_l;
   logic wr_tgl;
   logic rd_tgl;
   // read path
   logic [31:0] rd_data;
   logic [7:0] tx_byte;
   // link resets
   logic nrst_link;
   logic link_rst_n;

   // link reset: system reset or bus disabled
   // with the strap open the whole link side stays in reset, so the
   // port neither answers nor loads a control byte
   assign nrst_link = nrst_in && bus_enabled_out;

   // start flag set on sda fall while scl high, cleared by first scl rise
   // a start carries no scl edge, so sda itself clocks this flop; the
   // toggle pair lets the scl domain consume it without a second driver
   always_ff @(negedge sda_in or negedge nrst_link) begin
      if (!nrst_link) begin
         start_tgl <= 1'b0;
      end else if (scl_in) begin
         start_tgl <= ~start_ack;
      end
   end

   // stop flag set on sda rise while scl high
   // it falls again at the first sda rise with scl low, which every
   // address allowed here produces in its first bit
   always_ff @(posedge sda_in or negedge nrst_link) begin
      if (!nrst_link) begin
         stop_seen <= 1'b0;
      end else if (scl_in) begin
         stop_seen <= 1'b1;
      end else begin
         stop_seen <= 1'b0;
      end
   end

   // a start is pending while the two toggles differ
   assign start_seen = start_tgl ^ start_ack;
   // a stop releases sda at once; no scl edge follows to do it
   assign link_rst_n = nrst_link && !(stop_seen && scl_in);

   // sample sda on scl rise: shift, count bits and bytes
   always_ff @(posedge scl_in or negedge nrst_link) begin
      if (!nrst_link) begin
         state <= ACD_IDLE;
         shreg <= 8'h00;
         bitcnt <= 3'h0;
         bytecnt <= 3'h0;
         is_read <= 1'b0;
         start_ack <= 1'b0;
         ctrl_a_l <= `ACD_CTRL_RESET;
         ctrl_b_l <= `ACD_CTRL_RESET;
         wr_tgl <= 1'b0;
         rd_tgl <= 1'b0;
      end else if (start_seen) begin
         start_ack <= start_tgl; // consume start, take first address bit
         state <= ACD_ADDR;
         shreg <= {7'h00, sda_in};
         bitcnt <= 3'h1;
         bytecnt <= 3'h0;
      end else if (stop_seen) begin
         state <= ACD_IDLE;
      end else begin
         case (state)
            // address and write bytes shift in msb first
            ACD_ADDR, ACD_WDAT: begin
               shreg <= {shreg[6:0], sda_in};
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == 3'h7) begin
                  state <= (state == ACD_ADDR) ? ACD_AACK : ACD_WACK;
               end
            end
            // address compared while the ack is on the line
            ACD_AACK: begin
               if (shreg[7:1] == own_addr) begin
                  is_read <= shreg[`ACD_RW_BIT];
                  state <= shreg[`ACD_RW_BIT] ? ACD_RDAT : ACD_WDAT;
                  if (shreg[`ACD_RW_BIT]) begin
                     rd_tgl <= ~rd_tgl;
                  end
               end else begin
                  state <= ACD_IDLE;
               end
               bitcnt <= 3'h0;
            end
            // byte taken at the ack clock; surplus bytes acked, dropped
            ACD_WACK: begin
               if (bytecnt == 3'h0) begin
                  ctrl_a_l <= shreg;
               end else if (bytecnt == 3'h1) begin
                  ctrl_b_l <= shreg;
                  wr_tgl <= ~wr_tgl;
               end
               if (bytecnt < `ACD_CTRL_BYTES) begin
                  bytecnt <= bytecnt + 3'h1;
               end
               state <= ACD_WDAT;
               bitcnt <= 3'h0;
            end
            // data bits leave on scl fall, counted here on the rise
            ACD_RDAT: begin
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == 3'h7) begin
                  state <= ACD_RACK;
               end
            end
            // master ack asks for one more byte, nack ends the read
            ACD_RACK: begin
               bitcnt <= 3'h0;
               if (sda_in) begin
                  state <= ACD_IDLE; // master nack ends the read
               end else begin
                  state <= ACD_RDAT;
                  if (bytecnt < `ACD_DIAG_BYTES) begin
                     bytecnt <= bytecnt + 3'h1;
                  end
               end
            end
            default: state <= ACD_IDLE;
         endcase
      end
   end

   // ******************************
   // read path
   // ******************************
   // read data frozen at the address ack, from the previous cycle
   // the snapshot is quiet here: it moves only after the restart that
   // this very ack triggers, a few system clocks later
   always_ff @(posedge scl_in or negedge nrst_link) begin
      if (!nrst_link) begin
         rd_data <= 32'h0;
      end else if (state == ACD_AACK) begin
         rd_data <= diag_snap;
      end
   end

   // byte selection; beyond the fourth byte returns ones
   always_comb begin
      case (bytecnt)
         3'h0: tx_byte = rd_data[31:24];
         3'h1: tx_byte = rd_data[23:16];
         3'h2: tx_byte = rd_data[15:8];
         3'h3: tx_byte = rd_data[7:0];
         default: tx_byte = 8'hff;
      endcase
   end

   // ******************************
   // sda driver
   // ******************************
   // drive sda on scl fall only, so it is stable while scl high
   always_ff @(negedge scl_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sda_oe_out <= 1'b0;
      end else begin
         case (state)
            ACD_AACK: sda_oe_out <= (shreg[7:1] == own_addr);
            ACD_WACK: sda_oe_out <= 1'b1;
            ACD_RDAT: sda_oe_out <= is_read && ~tx_byte[3'h7 - bitcnt];
            default: sda_oe_out <= 1'b0; // released for master ack
         endcase
      end
   end
   assign sda_out = 1'b0;

   // ******************************
   // back to the system domain
   // ******************************
   logic wr_s;
   logic wr_d;
   logic rd_s;
   logic rd_d;

   // toggles cross as single bits; the data they announce is already still
   acd_sync u_wr_sync (
      .clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .d_in(wr_tgl),
      .q_out(wr_s)
   );

   // one toggle per addressed read
   acd_sync u_rd_sync (
      .clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .d_in(rd_tgl),
      .q_out(rd_s)
   );

   // control bytes taken when the second byte toggle arrives
   // one toggle per write, so both bytes arrive together; a write cut
   // after control a leaves the outputs as they were
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_d <= 1'b0;
         ctrl_a_out <= `ACD_CTRL_RESET;
         ctrl_b_out <= `ACD_CTRL_RESET;
      end else begin
         wr_d <= wr_s;
         if (wr_s != wr_d) begin
            ctrl_a_out <= ctrl_a_l;
            ctrl_b_out <= ctrl_b_l;
         end
      end
   end

   // restart pulse and fresh snapshot on each read
   // one pulse per addressed read, whatever the number of bytes read
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_d <= 1'b0;
         diag_restart_out <= 1'b0;
         diag_snap <= '0;
      end else begin
         rd_d <= rd_s;
         diag_restart_out <= (rd_s != rd_d);
         if (rd_s != rd_d) begin
            diag_snap <= next_diag_snap;
         end
      end
   end

endmodule
`default_nettype wire

// ==== src/acd_sync.sv ====
// acd_sync.sv: two-flop synchroniser for one level
// assumes: destination clock and async active low reset
`timescale 1ns/1ps
`default_nettype none
module acd_sync (
   input wire logic clk_in, // destination clock
   input wire logic nrst_in, // async reset, active low
   input wire logic d_in, // level from another domain
   output logic q_out // synchronised level
);
   logic meta;
   // ******************************
   // two stages, first read only by second
   // ******************************
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== verification/acd_host_model.sv ====
// acd_host_model.sv: behavioural bus master for the serial port
// assumes: sda is open drain with a pull-up, resolved outside
`timescale 1ns/1ps
`default_nettype none
module acd_host_model (
   output logic scl_out, // bus clock, high when idle
   output logic sda_oe_out, // pull sda low
   input wire logic sda_in // resolved sda level
);
   localparam realtime Q = 31.25; // quarter of the 125 ns bus clock
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // one clock: set data a quarter after scl fell, sample mid high
   task automatic bit_io(input logic tx, output logic rx);
      sda_oe_out = !tx;
      #Q;
      scl_out = 1'b1;
      #Q;
      rx = sda_in;
      #Q;
      scl_out = 1'b0;
      #Q;
   endtask
   task automatic start();
      sda_oe_out = 1'b0;
      #Q;
      scl_out = 1'b1;
      #Q;
      sda_oe_out = 1'b1;
      #Q;
      scl_out = 1'b0;
      #Q;
   endtask
   // clock stands high after the stop
   task automatic stop();
      sda_oe_out = 1'b1;
      #Q;
      scl_out = 1'b1;
      #Q;
      sda_oe_out = 1'b0;
      #Q;
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic recv(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(!ack, r);
   endtask
endmodule
`default_nettype wire

// ==== verification/acd_port_bench.sv ====
// acd_port_bench.sv: self-checking bench for acd_port
// assumes: acd_host_model drives scl and the master side of sda
`timescale 1ns/1ps
`default_nettype none
`include "acd_regs.svh"
module acd_port_bench;
   import acd_pkg::*;
   logic sys_clk, nrst, scl, sda, dut_oe, m_oe, dut_sda, bus_en, restart, done;
   logic [1:0] sel;
   logic [39:0] rd_d;
   acd_diag_t diag;
   acd_ctrl_a_t ca;
   acd_ctrl_b_t cb;
   int mismatches = 0;
   int n_compared = 0;
   int n_restart = 0;
   int r0;
   // open-drain line with pull-up
   assign sda = !(m_oe || (dut_oe && !dut_sda));
   acd_port acd_port_inst (.sys_clk_in(sys_clk), .nrst_in(nrst), .scl_in(scl), .sda_in(sda),
      .sda_out(dut_sda), .sda_oe_out(dut_oe), .addr_sel_in(sel), .diag_in(diag),
      .diag_cycle_done_in(done), .ctrl_a_out(ca), .ctrl_b_out(cb), .bus_enabled_out(bus_en),
      .diag_restart_out(restart));
   acd_host_model acd_host_model_inst (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (restart === 1'b1) n_restart <= n_restart + 1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic rst(input logic [1:0] s);
      @(posedge sys_clk);
      nrst <= 1'b0;
      sel <= s;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
   // address; on a hit, two controls and one surplus byte
   task automatic wr(input logic [6:0] ad, input logic [7:0] a, input logic [7:0] b, input logic hit);
      logic k;
      acd_host_model_inst.start();
      acd_host_model_inst.send({ad, 1'b0}, k);
      check(k, hit);
      if (hit) begin
         acd_host_model_inst.send(a, k);
         check(k, 1'b1);
         acd_host_model_inst.send(b, k);
         check(k, 1'b1);
         acd_host_model_inst.send(~b, k);
         check(k, 1'b1);
      end
      acd_host_model_inst.stop();
      repeat (8) @(posedge sys_clk);
   endtask
   // four diagnostic bytes and one extra, last one refused
   task automatic rd();
      logic k;
      acd_host_model_inst.start();
      acd_host_model_inst.send({`ACD_ADDR_LOW, 1'b1}, k);
      check(k, 1'b1);
      for (int j = 4; j >= 0; j--) begin
         acd_host_model_inst.recv(j != 0, rd_d[j*8 +: 8]);
      end
      acd_host_model_inst.stop();
      repeat (8) @(posedge sys_clk);
   endtask
   // main sequence
   initial begin
      nrst = 1'b0;
      sel = `ACD_SEL_LOW;
      diag = '0;
      done = 1'b0;
      for (int s = 0; s < 3; s++) begin
         rst(2'(s));
         check(bus_en, 1'b1);
         wr(7'(`ACD_ADDR_LOW + s), 8'ha5, 8'h3c, 1'b1);
         check(ca, 8'ha5);
         check(cb, 8'h3c);
      end
      wr(`ACD_ADDR_LOW, 8'h00, 8'h00, 1'b0);
      check(ca, 8'ha5);
      rst(`ACD_SEL_LOW);
      check(ca, `ACD_CTRL_RESET);
      wr(`ACD_ADDR_LOW, 8'h5a, 8'hc3, 1'b1);
      check(ca.mute_thr_high, 1'b0);
      check(ca.diag_en, 1'b1);
      check(ca.front_gain_16db, 1'b1);
      check(ca.clip_thr_10pct, 1'b0);
      check(cb.cur_thr_low, 1'b1);
      check(cb.fast_mute, 1'b0);
      check(cb.left_high_eff, 1'b1);
      r0 = n_restart;
      @(posedge sys_clk);
      diag <= 32'h9d112233;
      done <= 1'b1;
      rd();
      @(posedge sys_clk);
      diag <= '0;
      rd();
      check(rd_d[39:8], 32'hdd112233);
      check(rd_d[38], 1'b1);
      check(rd_d[7:0], 8'hff);
      rd();
      check(rd_d[39:8], 32'h40000000);
      check(n_restart - r0, 3);
      rst(`ACD_SEL_OPEN);
      check(bus_en, 1'b0);
      wr(`ACD_ADDR_LOW, 8'hff, 8'hff, 1'b0);
      summarize();
   end
   // watchdog well past the expected run
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
endmodule
bind acd_port acd_port_chk acd_port_chk_inst (.sys_clk_in, .nrst_in, .scl_in, .sda_out, .sda_oe_out,
   .addr_sel_in, .ctrl_a_out, .ctrl_b_out, .bus_enabled_out, .diag_restart_out);
`default_nettype wire

// ==== verification/acd_port_chk.sv ====
// acd_port_chk.sv: port assertions for acd_port
// assumes: bound to acd_port, one sys_clk_in domain
`timescale 1ns/1ps
`default_nettype none
`include "acd_regs.svh"
module acd_port_chk (
   input wire logic sys_clk_in, // system clock
   input wire logic nrst_in, // reset, active low
   input wire logic scl_in, // bus clock
   input wire logic sda_out, // sda drive value
   input wire logic sda_oe_out, // sda pull-down enable
   input wire logic [1:0] addr_sel_in, // strap class
   input wire acd_pkg::acd_ctrl_a_t ctrl_a_out, // control a
   input wire acd_pkg::acd_ctrl_b_t ctrl_b_out, // control b
   input wire logic bus_enabled_out, // bus on
   input wire logic diag_restart_out // restart pulse
);
   import acd_pkg::*;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   // the pull-down moves only while scl is low
   a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("sda drive moved with scl high");
   // a driven low bit stays for eight system clocks after scl rises
   a_ack_held: assert property ($rose(scl_in) && sda_oe_out |=> sda_oe_out [*8])
      else $error("sda low dropped in scl high");
   // driving means pulling low
   a_drive_low: assert property (sda_oe_out |-> !sda_out)
      else $error("sda driven high");
   // an open strap keeps the port off the bus
   a_open_quiet: assert property (!bus_enabled_out |-> !sda_oe_out)
      else $error("sda driven with bus off");
   a_strap_open: assert property (bus_enabled_out |-> addr_sel_in != `ACD_SEL_OPEN)
      else $error("bus on with open strap");
   // restart is a single cycle and needs the bus
   a_restart_pulse: assert property (diag_restart_out |=> !diag_restart_out)
      else $error("restart longer than a cycle");
   a_restart_bus: assert property (diag_restart_out |-> bus_enabled_out)
      else $error("restart with bus off");
   // controls leave reset cleared
   a_ctrl_reset: assert property ($rose(nrst_in) |-> ctrl_a_out == `ACD_CTRL_RESET
      && ctrl_b_out == `ACD_CTRL_RESET)
      else $error("controls not cleared");
endmodule
`default_nettype wire
